// [ivc_pkg.sv]
// Constants, register map and vector arithmetic for the interrupt priority and vectoring block.
// Assumes a 16-bit register port with word indices and a single system clock.
package ivc_pkg;

    localparam int unsigned DATA_W        = 16;
    localparam int unsigned ADDR_W        = 5;
    localparam int unsigned NUM_SRC       = 72;
    localparam int unsigned NUM_FLAG_REGS = 5;
    localparam int unsigned NUM_PRIO_REGS = 18;
    localparam int unsigned PRIO_PER_REG  = 4;
    localparam int unsigned PRIO_W        = 3;
    localparam int unsigned LEVEL_W       = 4;
    localparam int unsigned NUM_TRAP      = 8;
    localparam int unsigned NUM_EXT       = 5;
    localparam int unsigned VNUM_W        = 7;
    localparam int unsigned VADDR_W       = 24;
    localparam int unsigned SRC_IDX_W     = 7;

    // Register word indices.
    localparam logic [ADDR_W-1:0] ADDR_CTRL_A      = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_B      = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_FLAG0       = 5'h02;
    localparam logic [ADDR_W-1:0] ADDR_ENABLE0     = 5'h07;
    localparam logic [ADDR_W-1:0] ADDR_PRIO0       = 5'h0c;
    localparam logic [ADDR_W-1:0] ADDR_CPU_STATUS  = 5'h1e;
    localparam logic [ADDR_W-1:0] ADDR_CORE_CTRL   = 5'h1f;

    // Field positions.
    localparam int unsigned NESTING_DISABLE_BIT      = 15;
    localparam int unsigned ALT_SEL_BIT     = 15;
    localparam int unsigned EXT_POL_LSB     = 0;
    localparam int unsigned IPL_LSB         = 5;
    localparam int unsigned PRIORITY_LEVEL_MSB_BIT        = 3;
    localparam int unsigned ST_OSC_FAIL_BIT = 1;
    localparam int unsigned ST_STACK_BIT    = 2;
    localparam int unsigned ST_ADDR_BIT     = 3;
    localparam int unsigned ST_MATH_BIT     = 4;
    localparam int unsigned ST_DMA_BIT      = 5;

    localparam logic [DATA_W-1:0] CTRL_A_WMASK = 16'hfffe;
    localparam logic [DATA_W-1:0] CTRL_B_WMASK = 16'h801f;

    // Reset values and the highest priority level.
    localparam logic [DATA_W-1:0]  RST_CTRL   = 16'h0000;
    localparam logic [PRIO_W-1:0]  RST_IPL    = 3'h0;
    localparam logic               RST_PRIORITY_LEVEL_MSB   = 1'b0;
    localparam logic [PRIO_W-1:0]  IPL_MAX    = 3'h7;

    // Trap vector numbers.
    localparam logic [VNUM_W-1:0] TRAP_OSC_FAIL = 7'h01;
    localparam logic [VNUM_W-1:0] TRAP_ADDR_ERR = 7'h02;
    localparam logic [VNUM_W-1:0] TRAP_STACK    = 7'h03;
    localparam logic [VNUM_W-1:0] TRAP_MATH     = 7'h04;
    localparam logic [VNUM_W-1:0] TRAP_DMA      = 7'h05;

    // Request numbers of note.
    localparam int unsigned SRC_DMA_CH4     = 46;
    localparam int unsigned SRC_EXT_LINE3   = 53;
    localparam int unsigned SRC_EXT_LINE4   = 54;
    localparam int unsigned SRC_UART1_ERR   = 65;
    localparam int unsigned SRC_UART2_ERR   = 66;
    localparam int unsigned SRC_CAN1_TX     = 70;
    localparam int unsigned SRC_CAN2_TX     = 71;
    localparam int unsigned EXT_LINE_SRC [NUM_EXT] = '{0, 20, 29, SRC_EXT_LINE3, SRC_EXT_LINE4};

    // Requests 57-60, 62-64 and 67 are unimplemented and hold zero.
    localparam logic [NUM_SRC-1:0] SRC_IMPL_MASK = 72'hf6_21ff_ffff_ffff_ffff;

    // Vector table layout.
    localparam logic [VNUM_W-1:0]  IRQ_VEC_BIAS    = 7'h08;
    localparam logic [VADDR_W-1:0] VEC_BASE        = 24'h000004;
    localparam logic [VADDR_W-1:0] IRQ_ALT_OFFSET  = 24'h000100;
    localparam logic [VADDR_W-1:0] TRAP_ALT_OFFSET = 24'h000080;

    // One word per vector; the alternate table is displaced by a trap- or irq-specific offset.
    function automatic logic [VADDR_W-1:0] vec_addr(input logic [VNUM_W-1:0] vnum,
                                                    input logic              alt,
                                                    input logic              trap);
        logic [VADDR_W-1:0] a;
        a = VEC_BASE + {16'h0000, vnum, 1'b0};
        if (alt) begin
            a = a + (trap ? TRAP_ALT_OFFSET : IRQ_ALT_OFFSET);
        end
        return a;
    endfunction : vec_addr

endpackage : ivc_pkg

// [ivc_ext_edge.sv]
// Synchroniser and edge detector for the external interrupt lines.
// Assumes asynchronous pins and a polarity select held in a control register.
`timescale 1ns/1ps
module ivc_ext_edge
    import ivc_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_sys_rst,
    input  wire logic [NUM_EXT-1:0] i_line,
    input  wire logic [NUM_EXT-1:0] i_neg_pol,
    output logic      [NUM_EXT-1:0] o_edge
);

    typedef struct packed {
        logic [NUM_EXT-1:0] s1;
        logic [NUM_EXT-1:0] s2;
        logic [NUM_EXT-1:0] s3;
        logic [NUM_EXT-1:0] edge_det;
    } ivc_edge_state_t;

    ivc_edge_state_t st_q;
    ivc_edge_state_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = i_line;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // A polarity bit of one selects the falling edge.
        st_d.edge_det = (i_neg_pol & st_q.s3 & ~st_q.s2) | (~i_neg_pol & ~st_q.s3 & st_q.s2);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_edge = st_q.edge_det;

endmodule : ivc_ext_edge

// [ivc_arbiter.sv]
// Combinational winner selection among pending user interrupt sources.
// Assumes pending already combines flag and enable.
`timescale 1ns/1ps
module ivc_arbiter
    import ivc_pkg::*;
(
    input  wire logic [NUM_SRC-1:0]        i_pending,
    input  wire logic [NUM_SRC*PRIO_W-1:0] i_prio,
    input  wire logic [LEVEL_W-1:0]        i_level,
    output logic                           o_valid,
    output logic      [SRC_IDX_W-1:0]      o_src,
    output logic      [PRIO_W-1:0]         o_prio
);

    always_comb begin
        o_valid = 1'b0;
        o_src   = '0;
        o_prio  = '0;
        // Ascending scan with a strict compare keeps ties on the lower request number.
        for (int k = 0; k < NUM_SRC; k++) begin
            if (i_pending[k] && ({1'b0, i_prio[k*PRIO_W +: PRIO_W]} > i_level)) begin
                if (!o_valid || (i_prio[k*PRIO_W +: PRIO_W] > o_prio)) begin
                    o_valid = 1'b1;
                    o_src   = SRC_IDX_W'(k);
                    o_prio  = i_prio[k*PRIO_W +: PRIO_W];
                end
            end
        end
    end

endmodule : ivc_arbiter

// [ivc_top.sv]
// Interrupt priority and vectoring controller: registers, level keeping and vector output.
// Assumes a register master on the same clock, peripheral requests as same-clock pulses,
// external lines as asynchronous pins, and a core that acknowledges a presented vector.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module ivc_top
    import ivc_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_sys_rst,
    input  wire logic [ADDR_W-1:0]     i_addr,
    input  wire logic [DATA_W-1:0]     i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [DATA_W-1:0]     o_rdata,
    input  wire logic [NUM_SRC-1:0]    i_src_req,
    input  wire logic [NUM_EXT-1:0]    i_ext_line,
    input  wire logic [NUM_TRAP-1:0]   i_trap_event,
    input  wire logic                  i_vec_ack,
    input  wire logic                  i_level_restore,
    input  wire logic [LEVEL_W-1:0]    i_restore_level,
    output logic                       o_irq_req,
    output logic      [VNUM_W-1:0]     o_vector_num,
    output logic      [VADDR_W-1:0]    o_vector_addr,
    output logic      [LEVEL_W-1:0]    o_cpu_level,
    output logic                       o_nesting_disable
);

    typedef struct packed {
        logic [DATA_W-1:0]                                   ctrl_a;
        logic [DATA_W-1:0]                                   ctrl_b;
        logic [NUM_FLAG_REGS-1:0][DATA_W-1:0]                flags;
        logic [NUM_FLAG_REGS-1:0][DATA_W-1:0]                enables;
        logic [NUM_PRIO_REGS-1:0][PRIO_PER_REG-1:0][PRIO_W-1:0] prio;
        logic [PRIO_W-1:0]                                   cpu_priority_level;
        logic                                                priority_level_msb;
        logic [DATA_W-1:0]                                   rdata;
        logic                                                irq;
        logic                                                trap_sel;
        logic [VNUM_W-1:0]                                   vnum;
        logic [VADDR_W-1:0]                                  vaddr;
    } ivc_state_t;

    ivc_state_t st_q;
    ivc_state_t st_d;

    localparam int unsigned FLAG_BITS = NUM_FLAG_REGS * DATA_W;

    logic [NUM_EXT-1:0]   ext_edge;
    logic [NUM_SRC-1:0]   src_set;
    logic [NUM_SRC-1:0]   pending;
    logic [LEVEL_W-1:0]   level;
    logic                 arb_valid;
    logic [SRC_IDX_W-1:0] arb_src;
    logic                 trap_valid;
    logic [VNUM_W-1:0]    trap_vnum;
    logic [DATA_W-1:0]    trap_set;
    logic                 nest_dis;

    ivc_ext_edge u_ext_edge (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_line    (i_ext_line),
        .i_neg_pol (st_q.ctrl_b[EXT_POL_LSB +: NUM_EXT]),
        .o_edge    (ext_edge)
    );

    // External lines arrive through the synchroniser; their raw request inputs are unused.
    always_comb begin
        src_set = i_src_req;
        for (int e = 0; e < NUM_EXT; e++) begin
            src_set[EXT_LINE_SRC[e]] = ext_edge[e];
        end
        src_set = src_set & SRC_IMPL_MASK;
    end

    assign level    = {st_q.priority_level_msb, st_q.cpu_priority_level};
    assign nest_dis = st_q.ctrl_a[NESTING_DISABLE_BIT];
    assign pending  = NUM_SRC'(st_q.flags) & NUM_SRC'(st_q.enables);

    ivc_arbiter u_arbiter (
        .i_pending (pending),
        .i_prio    (st_q.prio),
        .i_level   (level),
        .o_valid   (arb_valid),
        .o_src     (arb_src),
        .o_prio    ()
    );

    // Trap events land in the status bits of the first global control register.
    always_comb begin
        trap_set = '0;
        trap_set[ST_OSC_FAIL_BIT] = i_trap_event[TRAP_OSC_FAIL[2:0]];
        trap_set[ST_ADDR_BIT]     = i_trap_event[TRAP_ADDR_ERR[2:0]];
        trap_set[ST_STACK_BIT]    = i_trap_event[TRAP_STACK[2:0]];
        trap_set[ST_MATH_BIT]     = i_trap_event[TRAP_MATH[2:0]];
        trap_set[ST_DMA_BIT]      = i_trap_event[TRAP_DMA[2:0]];
    end

    // Lower trap vector numbers take precedence. A trap is only presented while the
    // upper level bit is clear, otherwise its still-set status bit would re-enter forever.
    always_comb begin
        trap_valid = 1'b0;
        trap_vnum  = '0;
        if (!st_q.priority_level_msb) begin
            if (st_q.ctrl_a[ST_DMA_BIT]) begin
                trap_valid = 1'b1;
                trap_vnum  = TRAP_DMA;
            end
            if (st_q.ctrl_a[ST_MATH_BIT]) begin
                trap_valid = 1'b1;
                trap_vnum  = TRAP_MATH;
            end
            if (st_q.ctrl_a[ST_STACK_BIT]) begin
                trap_valid = 1'b1;
                trap_vnum  = TRAP_STACK;
            end
            if (st_q.ctrl_a[ST_ADDR_BIT]) begin
                trap_valid = 1'b1;
                trap_vnum  = TRAP_ADDR_ERR;
            end
            if (st_q.ctrl_a[ST_OSC_FAIL_BIT]) begin
                trap_valid = 1'b1;
                trap_vnum  = TRAP_OSC_FAIL;
            end
        end
    end

    always_comb begin
        st_d       = st_q;
        st_d.rdata = '0;

        // Software writes; hardware sets are merged afterwards so a set never loses.
        if (i_wr) begin
            if (i_addr == ADDR_CTRL_A) begin
                st_d.ctrl_a = i_wdata & CTRL_A_WMASK;
            end
            if (i_addr == ADDR_CTRL_B) begin
                st_d.ctrl_b = i_wdata & CTRL_B_WMASK;
            end
            for (int r = 0; r < NUM_FLAG_REGS; r++) begin
                if (i_addr == ADDR_FLAG0 + ADDR_W'(r)) begin
                    st_d.flags[r] = i_wdata;
                end
                if (i_addr == ADDR_ENABLE0 + ADDR_W'(r)) begin
                    st_d.enables[r] = i_wdata;
                end
            end
            for (int r = 0; r < NUM_PRIO_REGS; r++) begin
                if (i_addr == ADDR_PRIO0 + ADDR_W'(r)) begin
                    for (int f = 0; f < PRIO_PER_REG; f++) begin
                        st_d.prio[r][f] = i_wdata[f*PRIO_PER_REG +: PRIO_W];
                    end
                end
            end
            if ((i_addr == ADDR_CPU_STATUS) && !nest_dis) begin
                st_d.cpu_priority_level = i_wdata[IPL_LSB +: PRIO_W];
            end
            if ((i_addr == ADDR_CORE_CTRL) && !i_wdata[PRIORITY_LEVEL_MSB_BIT]) begin
                st_d.priority_level_msb = 1'b0;
            end
        end

        st_d.ctrl_a = st_d.ctrl_a | trap_set;
        st_d.flags  = (st_d.flags | FLAG_BITS'(src_set)) & FLAG_BITS'(SRC_IMPL_MASK);
        st_d.enables = st_d.enables & FLAG_BITS'(SRC_IMPL_MASK);

        // The core restoring a stacked level overrides a software write in the same cycle.
        if (i_level_restore) begin
            st_d.priority_level_msb = i_restore_level[LEVEL_W-1];
            st_d.cpu_priority_level  = i_restore_level[PRIO_W-1:0];
        end

        // Taking a vector raises the level; the flag itself stays for software to clear.
        if (i_vec_ack && st_q.irq) begin
            if (st_q.trap_sel) begin
                st_d.priority_level_msb = 1'b1;
            end else if (nest_dis) begin
                st_d.cpu_priority_level = IPL_MAX;
            end else begin
                st_d.cpu_priority_level = arb_prio_taken(st_q.vnum);
            end
        end

        if (i_rd) begin
            case (i_addr)
                ADDR_CTRL_A: begin
                    st_d.rdata = st_q.ctrl_a;
                end
                ADDR_CTRL_B: begin
                    st_d.rdata = st_q.ctrl_b;
                end
                ADDR_CPU_STATUS: begin
                    st_d.rdata = DATA_W'({st_q.cpu_priority_level, 5'h00});
                end
                ADDR_CORE_CTRL: begin
                    st_d.rdata = DATA_W'({st_q.priority_level_msb, 3'h0});
                end
                default: begin
                    for (int r = 0; r < NUM_FLAG_REGS; r++) begin
                        if (i_addr == ADDR_FLAG0 + ADDR_W'(r)) begin
                            st_d.rdata = st_q.flags[r];
                        end
                        if (i_addr == ADDR_ENABLE0 + ADDR_W'(r)) begin
                            st_d.rdata = st_q.enables[r];
                        end
                    end
                    for (int r = 0; r < NUM_PRIO_REGS; r++) begin
                        if (i_addr == ADDR_PRIO0 + ADDR_W'(r)) begin
                            for (int f = 0; f < PRIO_PER_REG; f++) begin
                                st_d.rdata[f*PRIO_PER_REG +: PRIO_W] = st_q.prio[r][f];
                            end
                        end
                    end
                end
            endcase
        end

        // Traps outrank every user source and ignore the level field except its upper bit, which blocks them.
        st_d.irq      = trap_valid | arb_valid;
        st_d.trap_sel = trap_valid;
        if (trap_valid) begin
            st_d.vnum  = trap_vnum;
            st_d.vaddr = vec_addr(trap_vnum, st_q.ctrl_b[ALT_SEL_BIT], 1'b1);
        end else begin
            st_d.vnum  = arb_src + IRQ_VEC_BIAS;
            st_d.vaddr = vec_addr(arb_src + IRQ_VEC_BIAS, st_q.ctrl_b[ALT_SEL_BIT], 1'b0);
        end
    end

    // Priority of the source whose vector is currently presented.
    function automatic logic [PRIO_W-1:0] arb_prio_taken(input logic [VNUM_W-1:0] vnum);
        logic [SRC_IDX_W-1:0] s;
        s = vnum - IRQ_VEC_BIAS;
        return st_q.prio[s / PRIO_PER_REG][s % PRIO_PER_REG];
    endfunction : arb_prio_taken

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_q.ctrl_a   <= RST_CTRL;
            st_q.ctrl_b   <= RST_CTRL;
            st_q.flags    <= '0;
            st_q.enables  <= '0;
            st_q.prio     <= '0;
            st_q.cpu_priority_level      <= RST_IPL;
            st_q.priority_level_msb     <= RST_PRIORITY_LEVEL_MSB;
            st_q.rdata    <= '0;
            st_q.irq      <= 1'b0;
            st_q.trap_sel <= 1'b0;
            st_q.vnum     <= '0;
            st_q.vaddr    <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rdata           = st_q.rdata;
    assign o_irq_req         = st_q.irq;
    assign o_vector_num      = st_q.vnum;
    assign o_vector_addr     = st_q.vaddr;
    assign o_cpu_level       = level;
    assign o_nesting_disable = nest_dis;

endmodule : ivc_top

// [ivc_top_properties.sv]
// Concurrent checks on the ports of the interrupt vectoring block.
// Assumes the register map and field positions of the block package.
`timescale 1ns/1ps
module ivc_chk
    import ivc_pkg::*;
(
    input wire logic               i_clk,
    input wire logic               i_sys_rst,
    input wire logic [ADDR_W-1:0]  i_addr,
    input wire logic [DATA_W-1:0]  i_wdata,
    input wire logic               i_wr,
    input wire logic               i_rd,
    input wire logic [DATA_W-1:0]  o_rdata,
    input wire logic               i_vec_ack,
    input wire logic               i_level_restore,
    input wire logic               o_irq_req,
    input wire logic [VNUM_W-1:0]  o_vector_num,
    input wire logic [VADDR_W-1:0] o_vector_addr,
    input wire logic [LEVEL_W-1:0] o_cpu_level,
    input wire logic               o_nesting_disable
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    logic               alt_q;
    logic               alt_p;
    logic               sw_lvl;
    logic [VADDR_W-1:0] exp_addr;

    // The table select is shadowed twice because the vector lags the register by one edge.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            alt_q <= 1'b0;
            alt_p <= 1'b0;
        end else begin
            if (i_wr && i_addr == ADDR_CTRL_B) begin
                alt_q <= i_wdata[ALT_SEL_BIT];
            end
            alt_p <= alt_q;
        end
    end

    always_comb begin
        sw_lvl = i_wr && !i_vec_ack && !i_level_restore;
        exp_addr = 24'h000004 + {16'h0000, o_vector_num, 1'b0};
        if (alt_q) begin
            exp_addr = exp_addr + ((o_vector_num < 7'h08) ? 24'h000080 : 24'h000100);
        end
    end

    property p_rd_idle;
        !$past(i_rd) |-> o_rdata == 16'h0000;
    endproperty
    property p_rst_zero;
        $past(i_sys_rst) |-> o_cpu_level == 4'h0 && !o_irq_req && !o_nesting_disable;
    endproperty
    property p_msb_no_set;
        sw_lvl && i_addr == ADDR_CORE_CTRL && !o_cpu_level[3] |=> !o_cpu_level[3];
    endproperty
    property p_ro_nest;
        sw_lvl && i_addr == ADDR_CPU_STATUS && o_nesting_disable |=> $stable(o_cpu_level);
    endproperty
    property p_sw_lvl;
        sw_lvl && i_addr == ADDR_CPU_STATUS && !o_nesting_disable
            |=> o_cpu_level == {$past(o_cpu_level[3]), $past(i_wdata[7:5])};
    endproperty
    property p_block;
        $past(o_cpu_level) >= 4'h7 |-> !o_irq_req || o_vector_num < IRQ_VEC_BIAS;
    endproperty
    property p_vaddr;
        o_irq_req && alt_q == alt_p |-> o_vector_addr == exp_addr;
    endproperty
    property p_ack_nsd;
        o_nesting_disable && i_vec_ack && o_irq_req && o_vector_num >= IRQ_VEC_BIAS
            |=> o_cpu_level == 4'h7;
    endproperty
    property p_trap_ack;
        i_vec_ack && o_irq_req && o_vector_num < IRQ_VEC_BIAS |=> o_cpu_level[3];
    endproperty

    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    a_rst_zero: assert property (p_rst_zero) else $error("outputs not zero after reset");
    a_msb_no_set: assert property (p_msb_no_set) else $error("upper level bit set by write");
    a_ro_nest: assert property (p_ro_nest) else $error("level written while locked");
    a_sw_lvl: assert property (p_sw_lvl) else $error("level write not applied");
    a_block: assert property (p_block) else $error("user source taken at level 7");
    a_vaddr: assert property (p_vaddr) else $error("vector address mismatch");
    a_ack_nsd: assert property (p_ack_nsd) else $error("level not 7 after locked ack");
    a_trap_ack: assert property (p_trap_ack) else $error("trap ack left upper bit clear");

    c_user_ack: cover property (i_vec_ack && o_irq_req && o_vector_num >= IRQ_VEC_BIAS);
    c_trap_ack: cover property (i_vec_ack && o_irq_req && o_vector_num < IRQ_VEC_BIAS);
    c_alt_vec: cover property (o_irq_req && alt_q && alt_p);
endmodule : ivc_chk

bind ivc_top ivc_chk i_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_vec_ack(i_vec_ack),
    .i_level_restore(i_level_restore), .o_irq_req(o_irq_req), .o_vector_num(o_vector_num),
    .o_vector_addr(o_vector_addr), .o_cpu_level(o_cpu_level),
    .o_nesting_disable(o_nesting_disable));

// [ivc_core_model.sv]
// Core side model: takes a presented vector promptly or after a delay.
// Assumes the request output is registered and reflects an ack two edges later.
`timescale 1ns/1ps
module ivc_core_model (
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_irq_req,
    input  wire logic i_go,
    input  wire logic i_slow,
    output logic      o_vec_ack
);
    logic [2:0] cnt_q;
    logic       arm_q;

    // A hold-off after each ack keeps the core from acting on a stale request.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cnt_q     <= 3'h0;
            arm_q     <= 1'b0;
            o_vec_ack <= 1'b0;
        end else if (o_vec_ack) begin
            o_vec_ack <= 1'b0;
            cnt_q     <= 3'h3;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end else if (i_go && i_irq_req) begin
            if (i_slow && !arm_q) begin
                arm_q <= 1'b1;
                cnt_q <= 3'h4;
            end else begin
                arm_q     <= 1'b0;
                o_vec_ack <= 1'b1;
            end
        end
    end
endmodule : ivc_core_model

// [test_interrupt_priority_vectoring.sv]
// Self-checking bench for the interrupt vectoring block with a core model.
// Assumes the register map of the block package and a 250 MHz clock.
`timescale 1ns/1ps
module test_interrupt_priority_vectoring;
    import ivc_pkg::*;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, go = 1'b0, slow = 1'b0;
    logic i_level_restore = 1'b0, vec_ack, o_irq_req, o_nsd;
    logic [4:0] i_addr = '0, i_ext_line = '0;
    logic [15:0] i_wdata = '0, o_rdata;
    logic [71:0] i_src_req = '0;
    logic [7:0] i_trap_event = '0;
    logic [3:0] i_restore_level = '0, o_cpu_level;
    logic [6:0] o_vector_num;
    logic [23:0] o_vector_addr;
    logic [31:0] seed = 32'h98f3d90f;
    int err_total = 0, checks = 0;

    always #2 i_clk = ~i_clk;

    ivc_top i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_src_req(i_src_req),
        .i_ext_line(i_ext_line), .i_trap_event(i_trap_event), .i_vec_ack(vec_ack),
        .i_level_restore(i_level_restore), .i_restore_level(i_restore_level),
        .o_irq_req(o_irq_req), .o_vector_num(o_vector_num), .o_vector_addr(o_vector_addr),
        .o_cpu_level(o_cpu_level), .o_nesting_disable(o_nsd));
    ivc_core_model i_core (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_irq_req(o_irq_req),
        .i_go(go), .i_slow(slow), .o_vec_ack(vec_ack));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic [15:0] imask(input int r);
        logic [127:0] m;
        m = {56'h0, SRC_IMPL_MASK};
        return m[16*r +: 16];
    endfunction : imask
    task automatic results();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_vec(input logic [6:0] vn, input logic [23:0] va);
        checks++;
        if ({o_vector_num, o_vector_addr} !== {vn, va}) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, {o_vector_num, o_vector_addr}, {vn, va});
        end
    endtask : chk_vec
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk_reg(o_rdata, e);
    endtask : rd
    task automatic wait_vec(input logic [6:0] vn, input logic [23:0] va);
        int n;
        for (n = 0; n < 20; n++) begin
            @(posedge i_clk);
            #1;
            if (o_irq_req === 1'b1 && o_vector_num === vn) break;
        end
        if (n == 20) begin
            err_total++;
            results();
        end
        chk_vec(vn, va);
    endtask : wait_vec
    task automatic take(input logic [3:0] lvl);
        int n;
        @(posedge i_clk);
        go <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge i_clk);
            if (vec_ack === 1'b1) break;
        end
        go <= 1'b0;
        if (n == 20) begin
            err_total++;
            results();
        end
        #1 chk_reg({12'h0, o_cpu_level}, {12'h0, lvl});
    endtask : take
    task automatic restore(input logic [3:0] l);
        @(posedge i_clk);
        i_level_restore <= 1'b1;
        i_restore_level <= l;
        @(posedge i_clk);
        i_level_restore <= 1'b0;
    endtask : restore
    task automatic pulse(input logic [71:0] s, input logic [7:0] t);
        @(posedge i_clk);
        i_src_req <= s;
        i_trap_event <= t;
        @(posedge i_clk);
        i_src_req <= '0;
        i_trap_event <= '0;
    endtask : pulse

    initial begin
        repeat (12) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        for (int a = 0; a < 32; a++) rd(5'(a), 16'h0000);
        for (int r = 0; r < 5; r++) begin
            seed = xs(seed);
            wr(5'(ADDR_ENABLE0 + r), seed[15:0]);
            rd(5'(ADDR_ENABLE0 + r), seed[15:0] & imask(r));
            wr(5'(ADDR_ENABLE0 + r), 16'h0000);
        end
        for (int r = 0; r < 18; r++) begin
            seed = xs(seed);
            wr(5'(ADDR_PRIO0 + r), seed[15:0]);
            rd(5'(ADDR_PRIO0 + r), seed[15:0] & 16'h7777);
        end
        wr(5'h17, 16'h5300);
        wr(5'h18, 16'h0005);
        wr(5'h09, 16'hc000);
        wr(5'h0a, 16'h0001);
        pulse(72'h1 << 46, 8'h00);
        wait_vec(7'd54, 24'h000070);
        take(4'h3);
        rd(5'h04, 16'h4000);
        pulse((72'h1 << 47) | (72'h1 << 48), 8'h00);
        wait_vec(7'd55, 24'h000072);
        slow <= 1'b1;
        take(4'h5);
        restore(4'h2);
        wait_vec(7'd55, 24'h000072);
        wr(5'h04, 16'h4000);
        wait_vec(7'd56, 24'h000074);
        wr(5'h05, 16'h0000);
        wait_vec(7'd54, 24'h000070);
        wr(5'h01, 16'h8000);
        wait_vec(7'd54, 24'h000170);
        pulse('0, 8'h04);
        wait_vec(7'd2, 24'h000088);
        take(4'ha);
        rd(5'h00, 16'h0008);
        wr(5'h00, 16'h0000);
        wr(5'h1f, 16'h0008);
        rd(5'h1f, 16'h0008);
        wr(5'h1f, 16'h0000);
        wr(5'h1f, 16'h0008);
        rd(5'h1f, 16'h0000);
        wr(5'h1e, 16'h00e0);
        rd(5'h1e, 16'h00e0);
        chk_reg({12'h0, o_cpu_level}, 16'h0007);
        wr(5'h00, 16'h8000);
        wr(5'h1e, 16'h0000);
        rd(5'h1e, 16'h00e0);
        restore(4'h0);
        wait_vec(7'd54, 24'h000170);
        take(4'h7);
        wr(5'h01, 16'h0010);
        i_ext_line <= 5'h18;
        repeat (8) @(posedge i_clk);
        rd(5'h05, 16'h0020);
        @(posedge i_clk) i_ext_line <= 5'h08;
        repeat (8) @(posedge i_clk);
        rd(5'h05, 16'h0060);
        wr(5'h01, 16'hffff);
        rd(5'h01, 16'h801f);
        wr(5'h00, 16'hffff);
        rd(5'h00, 16'hfffe);
        results();
    end
endmodule : test_interrupt_priority_vectoring
